// file: logic/fabt_pkg.sv
package fabt_pkg;
	localparam int     CLK_PERIOD_NS    = 10;
	localparam longint CLK_HZ           = 64'd100000000;
	localparam int     ADDR_W           = 22;
	localparam int     DATA_W           = 16;
	localparam int     PAGE_BITS        = 3;
	localparam int     STATUS_READY_BIT = 7;
	localparam int     TMR_W            = 16;
	localparam int     TO_W             = 40;

	localparam int T_WP_NS        = 60;
	localparam int T_WPH_NS       = 30;
	localparam int T_PHWL_NS      = 150;
	localparam int T_WHGL_NS      = 30;
	localparam int T_ACC_NS       = 85;
	localparam int T_STS_EXTRA_NS = 40;
	localparam int T_QRY_EXTRA_NS = 100;
	localparam int T_PAGE_NS      = 35;
	localparam int T_HIZ_NS       = 20;
	localparam int T_PLPH_NS      = 100;
	localparam int T_VPH_NS       = 100;
	localparam int T_WHRL_NS      = 100;
	localparam int T_WORD_PROG_US = 200;
	localparam int T_PROG_SUSP_US = 10;
	localparam int T_ERAS_SUSP_US = 20;
	localparam int T_RST_ABORT_US = 22;
	localparam int RESUME_TO_SUSPEND_GAP_US      = 500;
	localparam int T_PARAM_ERASE_S = 4;
	localparam int T_MAIN_ERASE_S  = 5;
	localparam int T_CHIP_ERASE_S  = 700;

	// least times round up to whole cycles
	function automatic int ns2cyc(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int C_WP        = ns2cyc(T_WP_NS);
	localparam int C_WPH       = ns2cyc(T_WPH_NS);
	localparam int C_WHGL      = ns2cyc(T_WHGL_NS);
	localparam int C_WR_GAP    = (C_WPH > C_WHGL) ? C_WPH : C_WHGL;
	localparam int C_PHWL      = ns2cyc(T_PHWL_NS);
	localparam int C_ACC       = ns2cyc(T_ACC_NS);
	localparam int C_STS       = ns2cyc(T_ACC_NS + T_STS_EXTRA_NS);
	localparam int C_QRY       = ns2cyc(T_ACC_NS + T_QRY_EXTRA_NS);
	localparam int C_PAGE      = ns2cyc(T_PAGE_NS);
	localparam int C_HIZ       = ns2cyc(T_HIZ_NS);
	localparam int C_PLPH      = ns2cyc(T_PLPH_NS);
	localparam int C_VPH       = ns2cyc(T_VPH_NS);
	localparam int C_WHRL      = ns2cyc(T_WHRL_NS);
	localparam int C_PROG_SUSP = ns2cyc(T_PROG_SUSP_US * 1000);
	localparam int C_ERAS_SUSP = ns2cyc(T_ERAS_SUSP_US * 1000);
	localparam int C_RST_ABORT = ns2cyc(T_RST_ABORT_US * 1000);
	localparam int C_WORD_PROG = ns2cyc(T_WORD_PROG_US * 1000);
	localparam int C_ERES      = ns2cyc(RESUME_TO_SUSPEND_GAP_US * 1000);
	localparam longint C_PARAM_ERASE = T_PARAM_ERASE_S * CLK_HZ;
	localparam longint C_MAIN_ERASE  = T_MAIN_ERASE_S * CLK_HZ;
	localparam longint C_CHIP_ERASE  = T_CHIP_ERASE_S * CLK_HZ;

	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_WAIT, OP_RESET} fabt_op_e;
	typedef enum logic [2:0] {
		CL_WORD_PROG, CL_PARAM_ERASE, CL_MAIN_ERASE, CL_CHIP_ERASE,
		CL_PROG_SUSP, CL_ERAS_SUSP, CL_SHORT
	} fabt_class_e;

	typedef struct packed {
		fabt_op_e            op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                ce_ctrl;
		logic                query;
		fabt_class_e         cls;
		logic                resume;
		logic                suspend;
	} fabt_req_s;
endpackage

// file: logic/fabt_tmr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fabt_tmr_if;
	logic                       load;
	logic [fabt_pkg::TMR_W-1:0] value;
	logic                       expired;
	modport ctrl (output load, output value, input expired);
	modport tmr  (input load, input value, output expired);
endinterface
`default_nettype wire

// file: logic/fabt_timer.sv
`timescale 1ns/1ns
`default_nettype none
module fabt_timer import fabt_pkg::*; (
	input  wire logic clk,
	input  wire logic rst_n,
	fabt_tmr_if.tmr   t
);
	logic [TMR_W-1:0] cnt_q;
	logic [TMR_W-1:0] cnt_d;
	logic             exp_q;
	logic             exp_d;

	// expired rises exactly value edges after the load edge
	always_comb begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (t.load) begin
			cnt_d = t.value;
			exp_d = (t.value == '0);
		end else begin
			if (cnt_q != '0)
				cnt_d = cnt_q - 1'b1;
			exp_d = (cnt_q <= TMR_W'(1));
		end
	end

	// reset preloads the power-up hold so the flash reset stays low after release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= TMR_W'(C_VPH);
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign t.expired = exp_q;
endmodule
`default_nettype wire

// file: logic/fabt_host.sv
`timescale 1ns/1ns
`default_nettype none
module fabt_host import fabt_pkg::*; #(
	parameter logic [TO_W-1:0]  WORD_PROG_CYC   = TO_W'(C_WORD_PROG),
	parameter logic [TO_W-1:0]  PARAM_ERASE_CYC = TO_W'(C_PARAM_ERASE),
	parameter logic [TO_W-1:0]  MAIN_ERASE_CYC  = TO_W'(C_MAIN_ERASE),
	parameter logic [TO_W-1:0]  CHIP_ERASE_CYC  = TO_W'(C_CHIP_ERASE),
	parameter logic [TMR_W-1:0] RESUME_GAP_CYC  = TMR_W'(C_ERES)
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              req_valid,
	input  wire logic [1:0]        req_op,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic              req_ce_ctrl,
	input  wire logic              req_query,
	input  wire logic [2:0]        req_class,
	input  wire logic              req_resume,
	input  wire logic              req_suspend,
	output logic                   req_ready,
	output logic                   resp_valid,
	output logic [DATA_W-1:0]      resp_data,
	output logic                   resp_timeout,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n,
	output logic                   flash_rst_n,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [DATA_W-1:0]      flash_dq_o,
	output logic                   flash_dq_oe,
	input  wire logic [DATA_W-1:0] flash_dq_i,
	input  wire logic              flash_ready_busy_od
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_DISPATCH, ST_CLOSE, ST_RD_ACC, ST_WR_SETUP, ST_WR_PULSE,
		ST_WR_RISE, ST_WR_GAP, ST_WT_DELAY, ST_WT_ACC, ST_WT_CLOSE,
		ST_RS_LOW, ST_RS_ABORT, ST_RECOV
	} fabt_state_e;

	fabt_tmr_if tmr ();

	fabt_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.t     (tmr.tmr)
	);

	fabt_state_e       state_q, state_d;
	fabt_req_s         pend_q, pend_d;
	logic              pend_v_q, pend_v_d;
	logic              page_q, page_d;
	logic              ce_n_q, ce_n_d;
	logic              we_n_q, we_n_d;
	logic              oe_n_q, oe_n_d;
	logic              frst_n_q, frst_n_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] dqo_q, dqo_d;
	logic              dqoe_q, dqoe_d;
	logic              ready_q, ready_d;
	logic              rvalid_q, rvalid_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic              rto_q, rto_d;
	logic [TO_W-1:0]   to_q, to_d;
	logic [TMR_W-1:0]  gap_q, gap_d;
	logic              tmr_load;
	logic [TMR_W-1:0]  tmr_val;

	assign tmr.load  = tmr_load;
	assign tmr.value = tmr_val;

	// page hit: only the low page bits differ
	function automatic logic page_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:PAGE_BITS] == b[ADDR_W-1:PAGE_BITS];
	endfunction

	function automatic logic [TO_W-1:0] class_limit(input fabt_class_e c);
		case (c)
			CL_WORD_PROG:   return WORD_PROG_CYC;
			CL_PARAM_ERASE: return PARAM_ERASE_CYC;
			CL_MAIN_ERASE:  return MAIN_ERASE_CYC;
			CL_CHIP_ERASE:  return CHIP_ERASE_CYC;
			CL_PROG_SUSP:   return TO_W'(C_PROG_SUSP);
			CL_ERAS_SUSP:   return TO_W'(C_ERAS_SUSP);
			default:        return TO_W'(C_WHRL);
		endcase
	endfunction

	always_comb begin
		state_d  = state_q;
		pend_d   = pend_q;
		pend_v_d = pend_v_q;
		page_d   = page_q;
		ce_n_d   = ce_n_q;
		we_n_d   = we_n_q;
		oe_n_d   = oe_n_q;
		frst_n_d = frst_n_q;
		addr_d   = addr_q;
		dqo_d    = dqo_q;
		dqoe_d   = dqoe_q;
		rvalid_d = 1'b0;
		rdata_d  = rdata_q;
		rto_d    = rto_q;
		to_d     = (to_q != '0) ? to_q - 1'b1 : to_q;
		gap_d    = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
		tmr_load = 1'b0;
		tmr_val  = '0;
		case (state_q)
			ST_IDLE: begin
				if (req_valid && ready_q) begin
					pend_d.op      = fabt_op_e'(req_op);
					pend_d.addr    = req_addr;
					pend_d.wdata   = req_wdata;
					pend_d.ce_ctrl = req_ce_ctrl;
					pend_d.query   = req_query;
					pend_d.cls     = fabt_class_e'(req_class);
					pend_d.resume  = req_resume;
					pend_d.suspend = req_suspend;
					pend_v_d       = 1'b1;
					state_d        = ST_DISPATCH;
				end
			end
			ST_DISPATCH: begin
				if (pend_q.op == OP_READ && page_q && page_hit(pend_q.addr, addr_q)) begin
					// page stays open, only the low address bits move
					addr_d   = pend_q.addr;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_PAGE);
					state_d  = ST_RD_ACC;
				end else if (page_q) begin
					ce_n_d   = 1'b1;
					oe_n_d   = 1'b1;
					page_d   = 1'b0;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_HIZ);
					state_d  = ST_CLOSE;
				end else if (pend_q.op == OP_READ) begin
					addr_d   = pend_q.addr;
					we_n_d   = 1'b1;
					ce_n_d   = 1'b0;
					oe_n_d   = 1'b0;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_ACC);
					state_d  = ST_RD_ACC;
				end else if (pend_q.op == OP_WRITE) begin
					// a suspend too soon after a resume can starve the erase
					if (!(pend_q.suspend && gap_q != '0)) begin
						addr_d  = pend_q.addr;
						dqo_d   = pend_q.wdata;
						dqoe_d  = 1'b1;
						// non-controlling strobe falls first, setup of zero is allowed
						if (pend_q.ce_ctrl)
							we_n_d = 1'b0;
						else
							ce_n_d = 1'b0;
						state_d = ST_WR_SETUP;
					end
				end else if (pend_q.op == OP_WAIT) begin
					to_d     = class_limit(pend_q.cls);
					tmr_load = 1'b1;
					tmr_val  = pend_q.query ? TMR_W'(C_QRY) : TMR_W'(C_STS);
					state_d  = ST_WT_DELAY;
				end else begin
					frst_n_d = 1'b0;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_PLPH);
					state_d  = ST_RS_LOW;
				end
			end
			ST_CLOSE: begin
				if (tmr.expired)
					state_d = pend_v_q ? ST_DISPATCH : ST_IDLE;
			end
			ST_RD_ACC: begin
				if (tmr.expired) begin
					rdata_d  = flash_dq_i;
					rto_d    = 1'b0;
					rvalid_d = 1'b1;
					page_d   = 1'b1;
					pend_v_d = 1'b0;
					state_d  = ST_IDLE;
				end
			end
			ST_WR_SETUP: begin
				ce_n_d   = 1'b0;
				we_n_d   = 1'b0;
				tmr_load = 1'b1;
				tmr_val  = TMR_W'(C_WP);
				state_d  = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				if (tmr.expired) begin
					// controlling strobe rises first and ends the pulse
					if (pend_q.ce_ctrl)
						ce_n_d = 1'b1;
					else
						we_n_d = 1'b1;
					state_d = ST_WR_RISE;
				end
			end
			ST_WR_RISE: begin
				ce_n_d   = 1'b1;
				we_n_d   = 1'b1;
				dqoe_d   = 1'b0;
				tmr_load = 1'b1;
				tmr_val  = TMR_W'(C_WR_GAP);
				if (pend_q.resume)
					gap_d = RESUME_GAP_CYC;
				state_d  = ST_WR_GAP;
			end
			ST_WR_GAP: begin
				if (tmr.expired) begin
					rdata_d  = '0;
					rto_d    = 1'b0;
					rvalid_d = 1'b1;
					pend_v_d = 1'b0;
					state_d  = ST_IDLE;
				end
			end
			ST_WT_DELAY: begin
				if (tmr.expired) begin
					addr_d   = pend_q.addr;
					ce_n_d   = 1'b0;
					oe_n_d   = 1'b0;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_ACC);
					state_d  = ST_WT_ACC;
				end
			end
			ST_WT_ACC: begin
				if (tmr.expired) begin
					rdata_d  = flash_dq_i;
					ce_n_d   = 1'b1;
					oe_n_d   = 1'b1;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_HIZ);
					if (flash_dq_i[STATUS_READY_BIT]) begin
						rto_d    = 1'b0;
						rvalid_d = 1'b1;
						pend_v_d = 1'b0;
						state_d  = ST_CLOSE;
					end else begin
						state_d  = ST_WT_CLOSE;
					end
				end
			end
			ST_WT_CLOSE: begin
				if (tmr.expired) begin
					if (to_q == '0) begin
						rto_d    = 1'b1;
						rvalid_d = 1'b1;
						pend_v_d = 1'b0;
						state_d  = ST_IDLE;
					end else begin
						ce_n_d   = 1'b0;
						oe_n_d   = 1'b0;
						tmr_load = 1'b1;
						tmr_val  = TMR_W'(C_ACC);
						state_d  = ST_WT_ACC;
					end
				end
			end
			ST_RS_LOW: begin
				if (tmr.expired) begin
					// a pin still held low means an abort is running inside
					if (!flash_ready_busy_od) begin
						tmr_load = 1'b1;
						tmr_val  = TMR_W'(C_RST_ABORT);
						state_d  = ST_RS_ABORT;
					end else begin
						frst_n_d = 1'b1;
						tmr_load = 1'b1;
						tmr_val  = TMR_W'(C_PHWL);
						state_d  = ST_RECOV;
					end
				end
			end
			ST_RS_ABORT: begin
				if (tmr.expired || flash_ready_busy_od) begin
					frst_n_d = 1'b1;
					tmr_load = 1'b1;
					tmr_val  = TMR_W'(C_PHWL);
					state_d  = ST_RECOV;
				end
			end
			ST_RECOV: begin
				if (tmr.expired) begin
					if (pend_v_q) begin
						rdata_d  = '0;
						rto_d    = 1'b0;
						rvalid_d = 1'b1;
					end
					pend_v_d = 1'b0;
					state_d  = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		ready_d = (state_d == ST_IDLE);
	end

	// power-up enters the reset-low state with the flash reset low for the preloaded hold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q  <= ST_RS_LOW;
			pend_q   <= '0;
			pend_v_q <= 1'b0;
			page_q   <= 1'b0;
			ce_n_q   <= 1'b1;
			we_n_q   <= 1'b1;
			oe_n_q   <= 1'b1;
			frst_n_q <= 1'b0;
			addr_q   <= '0;
			dqo_q    <= '0;
			dqoe_q   <= 1'b0;
			ready_q  <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rto_q    <= 1'b0;
			to_q     <= '0;
			gap_q    <= '0;
		end else begin
			state_q  <= state_d;
			pend_q   <= pend_d;
			pend_v_q <= pend_v_d;
			page_q   <= page_d;
			ce_n_q   <= ce_n_d;
			we_n_q   <= we_n_d;
			oe_n_q   <= oe_n_d;
			frst_n_q <= frst_n_d;
			addr_q   <= addr_d;
			dqo_q    <= dqo_d;
			dqoe_q   <= dqoe_d;
			ready_q  <= ready_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rto_q    <= rto_d;
			to_q     <= to_d;
			gap_q    <= gap_d;
		end
	end

	assign req_ready    = ready_q;
	assign resp_valid   = rvalid_q;
	assign resp_data    = rdata_q;
	assign resp_timeout = rto_q;
	assign flash_ce_n   = ce_n_q;
	assign flash_we_n   = we_n_q;
	assign flash_oe_n   = oe_n_q;
	assign flash_rst_n  = frst_n_q;
	assign flash_addr   = addr_q;
	assign flash_dq_o   = dqo_q;
	assign flash_dq_oe  = dqoe_q;
endmodule
`default_nettype wire

// file: test/fabt_host_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module fabt_host_chk import fabt_pkg::*; (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              flash_ce_n,
	input wire logic              flash_we_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_rst_n,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic              flash_dq_oe
);
	logic strobe;
	// combined strobe: low only while both select and write strobe are low
	assign strobe = flash_ce_n | flash_we_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	wr_pulse_a: assert property ($fell(strobe) |-> !strobe [*6])
		else $error("write pulse shorter than six cycles");
	wr_gap_a: assert property ($rose(strobe) |-> (strobe && flash_oe_n) [*4])
		else $error("strobe or output enable low too soon after write");
	wr_data_a: assert property (!strobe |-> flash_dq_oe && flash_oe_n)
		else $error("data not driven through write pulse");
	rst_len_a: assert property ($fell(flash_rst_n) |-> !flash_rst_n [*8] ##1 !flash_rst_n [*2])
		else $error("flash reset pulse too short");
	rst_rec_a: assert property ($rose(flash_rst_n) |-> strobe [*8] ##1 strobe [*7])
		else $error("write strobe too soon after flash reset");
	rd_mode_a: assert property (!flash_oe_n |-> flash_we_n && !flash_ce_n && !flash_dq_oe)
		else $error("read without select or with write strobe");
	rd_acc_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8] ##1 !flash_oe_n)
		else $error("read closed before access time");
	page_acc_a: assert property (!flash_oe_n && $changed(flash_addr) |-> !flash_oe_n [*4])
		else $error("page read closed before page access time");

	cover property ($rose(strobe));
	cover property ($fell(flash_oe_n));
	cover property ($fell(flash_rst_n));
endmodule
bind fabt_host fabt_host_chk fabt_host_chk_i (.clk, .rst_n, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_rst_n,
	.flash_addr, .flash_dq_oe);
`default_nettype wire

// file: test/fabt_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fabt_flash_model import fabt_pkg::*; (
	input  wire logic              clk,
	input  wire logic              flash_ce_n,
	input  wire logic              flash_we_n,
	input  wire logic              flash_oe_n,
	input  wire logic              flash_rst_n,
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic [15:0]       busy_cyc,
	output logic [DATA_W-1:0]      flash_dq_i,
	output logic                   flash_ready_busy_od
);
	logic [15:0]       busy_q = 16'h0000;
	logic [4:0]        acc_q;
	logic [4:0]        need_q;
	logic [4:0]        rec_q;
	logic              strobe_q;
	logic              sel_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] last_q = 16'h5a5a;
	logic              sel;
	logic              valid;
	assign sel = !flash_ce_n && !flash_oe_n && flash_we_n;
	// data only once address and select have settled long enough
	assign valid = sel && flash_addr == addr_q && acc_q >= need_q && rec_q == 5'd15;
	// floating bus is modelled as a toggling pattern, not a held value
	assign flash_dq_i = !valid ? ~last_q : (busy_q != 16'h0000) ? 16'h0000 : flash_addr[15:0] | 16'h0080;
	assign flash_ready_busy_od = busy_q == 16'h0000;
	always_ff @(posedge clk) begin
		strobe_q <= flash_ce_n | flash_we_n;
		sel_q <= sel;
		addr_q <= flash_addr;
		last_q <= flash_dq_i;
		if (!flash_rst_n) begin
			// an abort keeps the pin low a little while, so the host must wait on it
			busy_q <= (busy_q > 16'd60) ? 16'd60 : busy_q - 16'(busy_q != 16'h0000);
			rec_q <= 5'd0;
		end else begin
			if (rec_q != 5'd15) rec_q <= rec_q + 5'd1;
			if (!strobe_q && (flash_ce_n | flash_we_n)) busy_q <= busy_cyc;
			else if (busy_q != 16'h0000) busy_q <= busy_q - 16'h0001;
		end
		if (!sel) begin
			acc_q <= 5'd0;
			need_q <= 5'(C_ACC);
		end else if (flash_addr != addr_q) begin
			acc_q <= 5'd1;
			need_q <= (sel_q && flash_addr[ADDR_W-1:PAGE_BITS] == addr_q[ADDR_W-1:PAGE_BITS]) ? 5'(C_PAGE) : 5'(C_ACC);
		end else if (acc_q != 5'd31) acc_q <= acc_q + 5'd1;
	end
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import fabt_pkg::*; ;
	localparam int PROG_CYC  = 200;
	localparam int ERASE_CYC = 2000;
	localparam int GAP_CYC   = 100;
	logic              clk;
	logic              rst_n;
	logic              req_valid;
	logic [1:0]        req_op;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_wdata;
	logic              req_ce_ctrl;
	logic              req_query;
	logic [2:0]        req_class;
	logic              req_resume;
	logic              req_suspend;
	logic              req_ready;
	logic              resp_valid;
	logic [DATA_W-1:0] resp_data;
	logic              resp_timeout;
	logic              flash_ce_n;
	logic              flash_we_n;
	logic              flash_oe_n;
	logic              flash_rst_n;
	logic [ADDR_W-1:0] flash_addr;
	logic [DATA_W-1:0] flash_dq_o;
	logic              flash_dq_oe;
	logic [DATA_W-1:0] flash_dq_i;
	logic              flash_ready_busy_od;
	logic [15:0]       busy_cyc;
	logic [DATA_W-1:0] wr_seen;
	int                miscompares = 0;
	int                total_checks = 0;
	int                lat;

	fabt_host #(.WORD_PROG_CYC(40'(PROG_CYC)), .PARAM_ERASE_CYC(40'(ERASE_CYC)), .MAIN_ERASE_CYC(40'(ERASE_CYC)),
		.CHIP_ERASE_CYC(40'(ERASE_CYC)), .RESUME_GAP_CYC(16'(GAP_CYC))) fabt_host_i (.clk, .rst_n, .req_valid,
		.req_op, .req_addr, .req_wdata, .req_ce_ctrl, .req_query, .req_class, .req_resume, .req_suspend,
		.req_ready, .resp_valid, .resp_data, .resp_timeout, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_rst_n,
		.flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ready_busy_od);
	fabt_flash_model fabt_flash_model_i (.clk, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_rst_n, .flash_addr,
		.busy_cyc, .flash_dq_i, .flash_ready_busy_od);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// word on the data pins while the combined write pulse is low
	always @(posedge clk)
		if (!flash_ce_n && !flash_we_n && flash_dq_oe) wr_seen <= flash_dq_o;

	task automatic give_verdict();
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// lat counts edges from taking to the edge after resp_valid
	task automatic run(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic ce, input logic q,
			input logic [2:0] cls, input logic res, input logic sus);
		req_op <= op;
		req_addr <= a;
		req_wdata <= a[15:0];
		req_ce_ctrl <= ce;
		req_query <= q;
		req_class <= cls;
		req_resume <= res;
		req_suspend <= sus;
		req_valid <= 1'b1;
		lat = 0;
		do begin @(posedge clk); lat++; end while (req_ready !== 1'b1 && lat < 3000);
		req_valid <= 1'b0;
		lat = 0;
		do begin @(posedge clk); lat++; end while (resp_valid !== 1'b1 && lat < 20000);
		check("response", {39'h0, resp_valid}, 40'h1);
	endtask

	task automatic t_read();
		run(2'd0, 22'h012345, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		check("read data", 40'(resp_data), 40'h23c5);
		check("read latency", 40'(lat), 40'd12);
		run(2'd0, 22'h012342, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		check("page data", 40'(resp_data), 40'h23c2);
		check("page latency", 40'(lat), 40'd7);
		run(2'd0, 22'h2abcd0, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		check("new page data", 40'(resp_data), 40'hbcd0);
	endtask

	task automatic t_write_poll();
		for (int ce = 0; ce < 2; ce++) begin
			busy_cyc <= 16'd30;
			run(2'd1, 22'(256 + ce), 1'(ce), 1'b0, 3'd0, 1'b0, 1'b0);
			check("write data", 40'(resp_data), 40'h0);
			check("write word", 40'(wr_seen), 40'(256 + ce));
			run(2'd2, 22'h000100, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
			check("ready bit", {39'h0, resp_data[STATUS_READY_BIT]}, 40'h1);
			check("no timeout", {39'h0, resp_timeout}, 40'h0);
		end
	endtask

	task automatic t_query();
		int plain;
		busy_cyc <= 16'd0;
		run(2'd1, 22'h000090, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		run(2'd2, 22'h000090, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		plain = lat;
		run(2'd1, 22'h000090, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		run(2'd2, 22'h000090, 1'b0, 1'b1, 3'd0, 1'b0, 1'b0);
		check("query delay", 40'(lat - plain), 40'(C_QRY - C_STS));
	endtask

	task automatic t_gap();
		int first;
		run(2'd1, 22'h000200, 1'b0, 1'b0, 3'd0, 1'b1, 1'b0);
		first = lat;
		run(2'd1, 22'h000200, 1'b0, 1'b0, 3'd0, 1'b0, 1'b1);
		check("suspend held off", {39'h0, first + lat >= GAP_CYC}, 40'h1);
		run(2'd1, 22'h000200, 1'b0, 1'b0, 3'd0, 1'b0, 1'b1);
		check("late suspend prompt", {39'h0, lat < GAP_CYC}, 40'h1);
	endtask

	task automatic t_classes();
		int lim [7] = '{PROG_CYC, ERASE_CYC, ERASE_CYC, ERASE_CYC, C_PROG_SUSP, C_ERAS_SUSP, 10};
		busy_cyc <= 16'hffff;
		run(2'd1, 22'h008000, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		for (int c = 0; c < 7; c++) begin
			run(2'd2, 22'h008000, 1'b0, 1'b0, 3'(c), 1'b0, 1'b0);
			check("timeout flag", {39'h0, resp_timeout}, 40'h1);
			check("timeout span", {39'h0, lat > lim[c] && lat <= lim[c] + 40}, 40'h1);
		end
		run(2'd3, 22'h0, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		check("reset op data", 40'(resp_data), 40'h0);
		check("abort wait", {39'h0, lat > 60 && lat < 100}, 40'h1);
		run(2'd2, 22'h008000, 1'b0, 1'b0, 3'd0, 1'b0, 1'b0);
		check("ready after abort", {38'h0, resp_timeout, resp_data[STATUS_READY_BIT]}, 40'h1);
	endtask

	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_op = 2'd0;
		req_addr = '0;
		req_wdata = '0;
		req_ce_ctrl = 1'b0;
		req_query = 1'b0;
		req_class = 3'd0;
		req_resume = 1'b0;
		req_suspend = 1'b0;
		busy_cyc = 16'h0000;
		repeat (20) @(posedge clk);
		check("reset pin", {38'h0, flash_rst_n, flash_ce_n & flash_we_n & flash_oe_n}, 40'h1);
		rst_n <= 1'b1;
		t_read();
		t_write_poll();
		t_query();
		t_gap();
		t_classes();
		give_verdict();
	end

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule
`default_nettype wire
